//--- design/seq_sync_pkg.sv
`default_nettype none
package seq_sync_pkg;

  // ---------------------------------------------------------------
  // Clocking and timing
  // ---------------------------------------------------------------
  localparam int unsigned SYSTEM_CLOCK_IN_HZ     = 20_000_000;
  localparam int unsigned LOCK_TIME_US   = 100;
  // Longest time, rounded down, at least one cycle
  localparam int unsigned LOCK_CYCLES_RAW = (LOCK_TIME_US * (SYSTEM_CLOCK_IN_HZ / 1_000_000));
  localparam int unsigned LOCK_CYCLES    = (LOCK_CYCLES_RAW < 1) ? 1 : LOCK_CYCLES_RAW;
  localparam int unsigned LOCK_W         = 12;
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES - 1);
  localparam int unsigned RESET_HOLD_CYCLES = 4;

  // ---------------------------------------------------------------
  // Sequencer sync clock
  // ---------------------------------------------------------------
  localparam int unsigned PERIOD_W      = 5;
  localparam logic [PERIOD_W-1:0] PERIOD_MIN = 5'h10;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = 5'h14;
  localparam int unsigned PERIODS_PER_SLOT = 4;
  localparam logic [1:0]  QUARTER_LAST  = 2'h3;
  localparam logic [2:0]  PERIOD_SEL_MAX = 3'h4;

  // ---------------------------------------------------------------
  // Byte clock ratio and lanes
  // ---------------------------------------------------------------
  localparam logic [2:0]  RATIO_TWO     = 3'h2;
  localparam logic [2:0]  RATIO_FOUR    = 3'h4;
  localparam int unsigned PORTS         = 16;
  localparam int unsigned LANE_RATE_MBPS = 444;
  localparam int unsigned BUF_DEPTH     = 2;

  typedef enum logic [1:0] {
    SEQ_MODE_TRISTATE = 2'h0,
    SEQ_MODE_DRIVE    = 2'h1,
    SEQ_MODE_RECEIVE  = 2'h2
  } seq_mode_t;

  // Gray codes along free -> locking -> locked
  typedef enum logic [1:0] {
    TREE_FREE    = 2'h0,
    TREE_LOCKING = 2'h1,
    TREE_LOCKED  = 2'h3
  } tree_state_t;

  // Lanes 0,1 slave stream, lanes 2,3 master stream
  typedef struct packed {
    logic [1:0] master_lanes;
    logic [1:0] slave_lanes;
  } port_lanes_t;

  typedef port_lanes_t [PORTS-1:0] lane_word_t;

  typedef struct packed {
    logic       pll_internal;
    logic       pll_ratio_four;
    seq_mode_t  seq_mode;
    logic [2:0] period_sel;
  } clk_cfg_t;

endpackage : seq_sync_pkg
`default_nettype wire

//--- design/lane_skid_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module lane_skid_buffer
  import seq_sync_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire lane_word_t in_data,
  input  wire logic       in_valid,
  output logic            in_ready,
  output lane_word_t      out_data,
  output logic            out_valid,
  input  wire logic       out_ready
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    lane_word_t [BUF_DEPTH-1:0] entry;
    logic [1:0]                 count;
    logic                       ready;
    logic                       valid;
  } buf_state_t;

  buf_state_t state_ff;
  buf_state_t nxt_state;

  // Entry 0 is the head; ready is registered so it looks one step ahead
  always_comb begin
    logic push;
    logic pop;
    push = in_valid & state_ff.ready;
    pop  = state_ff.valid & out_ready;
    nxt_state = state_ff;
    if (pop) begin
      nxt_state.entry[0] = state_ff.entry[1];
    end
    if (push) begin
      if (state_ff.count == 2'h0 || (state_ff.count == 2'h1 && pop)) begin
        nxt_state.entry[0] = in_data;
      end else begin
        nxt_state.entry[1] = in_data;
      end
    end
    nxt_state.count = state_ff.count + 2'(push) - 2'(pop);
    nxt_state.valid = (nxt_state.count != 2'h0);
    nxt_state.ready = (nxt_state.count != 2'(BUF_DEPTH));
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign in_ready  = state_ff.ready;
  assign out_valid = state_ff.valid;
  assign out_data  = state_ff.entry[0];

endmodule : lane_skid_buffer
`default_nettype wire

//--- design/seq_sync_clock_reset.sv
`timescale 1ns/1ps
`default_nettype none
module seq_sync_clock_reset
  import seq_sync_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire clk_cfg_t   cfg,
  input  wire logic       clock_start_event,
  input  wire logic       flush_reset,
  input  wire logic       self_test,
  input  wire logic       sequencer_sync_clock_in,
  output logic            sequencer_sync_clock_out,
  output logic            sequencer_sync_clock_oe,
  output logic            sequencer_sync_clock_aux,
  output logic            slot_start,
  output logic [2:0]      byte_clock_ratio,
  output logic            tree_clock_from_tree,
  output logic            tree_clock_ready,
  input  wire lane_word_t rx_lanes,
  input  wire logic       rx_valid,
  output logic            rx_ready,
  output lane_word_t      tx_lanes,
  output logic            tx_valid,
  input  wire logic       tx_ready
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    tree_state_t         tree;
    logic [LOCK_W-1:0]   lock_cnt;
    logic [PERIOD_W-1:0] phase;
    logic [1:0]          quarter;
    logic                sync_in_prev;
    logic                sync_out;
    logic                sync_oe;
    logic                sync_aux;
    logic                slot_start;
    logic [2:0]          ratio;
    logic                from_tree;
    logic                ready;
  } ctl_state_t;

  ctl_state_t state_ff;
  ctl_state_t nxt_state;

  // ---------------------------------------------------------------
  // Clock tree, sync counter and pin control
  // ---------------------------------------------------------------
  // Out-of-range period selects clamp to the longest period
  always_comb begin
    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] half;
    logic                gen_level;
    logic                rx_rise;
    logic                test_mode;
    logic                step_quarter;
    // Defaults: every field holds unless a branch below moves it
    period       = PERIOD_MAX;
    half         = '0;
    gen_level    = 1'b0;
    rx_rise      = 1'b0;
    step_quarter = 1'b0;
    test_mode    = flush_reset | self_test;
    nxt_state    = state_ff;

    // Byte clock multiplier for the clock generator
    if (cfg.pll_internal) begin
      nxt_state.ratio = cfg.pll_ratio_four ? RATIO_FOUR : RATIO_TWO;
    end else begin
      // Board must then supply twice the byte clock
      nxt_state.ratio = RATIO_TWO;
    end

    // Tree lock sequence after the clock start event
    unique case (state_ff.tree)
      TREE_FREE: begin
        // Without the internal PLL the board clock is already valid
        if (clock_start_event) begin
          // Count restarts from zero on every accepted start
          nxt_state.lock_cnt = '0;
          nxt_state.tree     = cfg.pll_internal ? TREE_LOCKING : TREE_LOCKED;
        end
      end
      TREE_LOCKING: begin
        if (state_ff.lock_cnt == LOCK_LAST) begin
          nxt_state.tree = TREE_LOCKED;
        end else begin
          nxt_state.lock_cnt = state_ff.lock_cnt + 1'b1;
        end
      end
      TREE_LOCKED: begin
        // Further start events are ignored until the next chip reset
        nxt_state.tree = TREE_LOCKED;
      end
      default: begin
        // Unused code: fall back to the free-running clock
        nxt_state.tree = TREE_FREE;
      end
    endcase

    // Ready and source select follow the next state, so neither lags
    nxt_state.ready     = (nxt_state.tree == TREE_LOCKED);
    // Feedback only makes sense once the tree carries the byte clock
    nxt_state.from_tree = (nxt_state.tree == TREE_LOCKED) && !test_mode;

    // Period in system clock cycles, one quarter of the slot
    if (cfg.period_sel <= PERIOD_SEL_MAX) begin
      period = PERIOD_MIN + PERIOD_W'(cfg.period_sel);
    end
    // High for the first half; an odd period spends its extra cycle low
    half = period >> 1;

    // Slot counter: phase within period, quarter within slot
    rx_rise = sequencer_sync_clock_in & ~state_ff.sync_in_prev;
    nxt_state.sync_in_prev = sequencer_sync_clock_in;
    nxt_state.slot_start   = 1'b0;
    if (cfg.seq_mode == SEQ_MODE_RECEIVE && rx_rise) begin
      // Slave realigns its sequencer to the master edge; a wrap on the
      // edge before has already counted this period, so count it once
      nxt_state.phase = PERIOD_W'(1);
      step_quarter    = (state_ff.phase != '0);
    end else if (state_ff.phase >= period - 1'b1) begin
      nxt_state.phase = '0;
      step_quarter    = 1'b1;
    end else begin
      nxt_state.phase = state_ff.phase + 1'b1;
    end

    // Four periods make one slot; the slot marker comes with the wrap
    if (step_quarter) begin
      if (state_ff.quarter == QUARTER_LAST) begin
        nxt_state.quarter    = '0;
        nxt_state.slot_start = 1'b1;
      end else begin
        nxt_state.quarter = state_ff.quarter + 1'b1;
      end
    end

    // Look one step ahead so the pin flop shows the new phase
    gen_level = (nxt_state.phase < half);

    // Pin direction and level
    unique case (cfg.seq_mode)
      SEQ_MODE_DRIVE: begin
        // Pin and aux share one level, so they cannot split
        nxt_state.sync_oe  = 1'b1;
        nxt_state.sync_out = gen_level;
        nxt_state.sync_aux = gen_level;
      end
      SEQ_MODE_RECEIVE: begin
        // Aux echoes the received pin one cycle late
        nxt_state.sync_oe  = 1'b0;
        nxt_state.sync_out = 1'b0;
        nxt_state.sync_aux = sequencer_sync_clock_in;
      end
      default: begin
        // Single device: pin floats, aux still shows local timing
        nxt_state.sync_oe  = 1'b0;
        nxt_state.sync_out = 1'b0;
        nxt_state.sync_aux = gen_level;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Register update
  // ---------------------------------------------------------------
  // No scan state lives here, so everything is cleared
  // Synchronous clear; the board holds reset for four cycles or more
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end


  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output comes straight from a state flop
  assign sequencer_sync_clock_out = state_ff.sync_out;
  assign sequencer_sync_clock_oe  = state_ff.sync_oe;
  assign sequencer_sync_clock_aux = state_ff.sync_aux;
  assign slot_start               = state_ff.slot_start;
  assign byte_clock_ratio         = state_ff.ratio;
  assign tree_clock_from_tree     = state_ff.from_tree;
  assign tree_clock_ready         = state_ff.ready;

  // ---------------------------------------------------------------
  // Lane data path
  // ---------------------------------------------------------------
  // Lane order is kept per port by the struct layout
  // Two words of slack, so a receiver stall drops nothing
  lane_skid_buffer u_lane_buf (
    .clk       (clk),
    .rstn      (rstn),
    .in_data   (rx_lanes),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (tx_lanes),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );

endmodule : seq_sync_clock_reset
`default_nettype wire

//--- tb/seq_sync_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sync_chk
  import seq_sync_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire clk_cfg_t   cfg,
  input wire logic       clock_start_event,
  input wire logic       flush_reset,
  input wire logic       self_test,
  input wire logic       sequencer_sync_clock_in,
  input wire logic       sequencer_sync_clock_out,
  input wire logic       sequencer_sync_clock_oe,
  input wire logic       sequencer_sync_clock_aux,
  input wire logic [2:0] byte_clock_ratio,
  input wire logic       tree_clock_from_tree,
  input wire logic       tree_clock_ready
);
  // ----------
  // Lock timer
  // ----------
  logic        go_ff;
  logic [11:0] lk_ff;
  // Later start pulses must not restart the count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      go_ff <= 1'b0;
      lk_ff <= 12'h000;
    end else if (go_ff || clock_start_event) begin
      go_ff <= 1'b1;
      lk_ff <= lk_ff + 12'h001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rst; $rose(rstn) |-> byte_clock_ratio == 3'h0 && !tree_clock_ready; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  property p_ratio; $past(rstn) |-> byte_clock_ratio ==
    (($past(cfg.pll_internal) && $past(cfg.pll_ratio_four)) ? RATIO_FOUR : RATIO_TWO); endproperty
  a_ratio: assert property (p_ratio) else $error("bad byte ratio");
  property p_oe; $past(rstn) |-> sequencer_sync_clock_oe ==
    ($past(cfg.seq_mode) == SEQ_MODE_DRIVE); endproperty
  a_oe: assert property (p_oe) else $error("bad sync enable");
  property p_aux; sequencer_sync_clock_oe |-> sequencer_sync_clock_aux == sequencer_sync_clock_out;
  endproperty
  a_aux: assert property (p_aux) else $error("aux differs");
  property p_rcv; $past(rstn) && $past(cfg.seq_mode) == SEQ_MODE_RECEIVE |->
    sequencer_sync_clock_aux == $past(sequencer_sync_clock_in) && !sequencer_sync_clock_out;
  endproperty
  a_rcv: assert property (p_rcv) else $error("received sync not echoed");
  // First high phase after reset is one short, so that rise is skipped
  property p_per; $rose(sequencer_sync_clock_out) && $past(rstn, 2) && sequencer_sync_clock_oe
    && cfg.period_sel == 3'h0 |-> sequencer_sync_clock_out[*8] ##1 !sequencer_sync_clock_out[*8]
    ##1 sequencer_sync_clock_out; endproperty
  a_per: assert property (p_per) else $error("bad sync period");
  // Helper counts the start edge too, so ready is seen one count past the lock time
  property p_lock; $rose(tree_clock_ready) |->
    lk_ff == (cfg.pll_internal ? 12'(LOCK_CYCLES + 1) : 12'h001); endproperty
  a_lock: assert property (p_lock) else $error("bad lock time");
  property p_tree; flush_reset || self_test |=> !tree_clock_from_tree; endproperty
  a_tree: assert property (p_tree) else $error("tree source in test");
  c_lock: cover property ($rose(tree_clock_ready));
  c_rcv: cover property (cfg.seq_mode == SEQ_MODE_RECEIVE && $rose(sequencer_sync_clock_aux));
  c_test: cover property (self_test && tree_clock_ready);
endmodule : sync_chk
bind seq_sync_clock_reset sync_chk chk_i (
  .clk                      (clk),
  .rstn                     (rstn),
  .cfg                      (cfg),
  .clock_start_event        (clock_start_event),
  .flush_reset              (flush_reset),
  .self_test                (self_test),
  .sequencer_sync_clock_in  (sequencer_sync_clock_in),
  .sequencer_sync_clock_out (sequencer_sync_clock_out),
  .sequencer_sync_clock_oe  (sequencer_sync_clock_oe),
  .sequencer_sync_clock_aux (sequencer_sync_clock_aux),
  .byte_clock_ratio         (byte_clock_ratio),
  .tree_clock_from_tree     (tree_clock_from_tree),
  .tree_clock_ready         (tree_clock_ready)
);
`default_nettype wire

//--- tb/sync_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module sync_master_model
#(
  parameter int PERIOD = 16
)
(
  input  wire logic clk,
  input  wire logic run,
  output logic      sync_o
);
  // -------------------
  // Expansion master
  // -------------------
  int ph = 0;
  initial sync_o = 1'b0;
  // Stopped master toggles the line so a stale level never looks live
  always @(posedge clk) begin
    if (!run) begin
      ph <= 0;
      sync_o <= !sync_o;
    end else begin
      ph <= (ph >= PERIOD - 1) ? 0 : ph + 1;
      sync_o <= (ph < PERIOD / 2);
    end
  end
endmodule : sync_master_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import seq_sync_pkg::*;
;
  logic       clk = 1'b0;
  logic       rstn, clock_start_event, flush_reset, self_test, run;
  logic       sequencer_sync_clock_in, sequencer_sync_clock_out;
  logic       sequencer_sync_clock_oe, sequencer_sync_clock_aux;
  logic       slot_start, tree_clock_from_tree, tree_clock_ready;
  logic       rx_valid, rx_ready, tx_valid, tx_ready;
  logic [2:0] byte_clock_ratio;
  clk_cfg_t   cfg;
  lane_word_t rx_lanes, tx_lanes;
  int         bad_count = 0;
  int         n_checks = 0;
  int         n, hi, hx;
  logic       v;
  // ----------------
  // Harness
  // ----------------
  always #25 clk = ~clk;
  seq_sync_clock_reset dut (
    .clk                      (clk),
    .rstn                     (rstn),
    .cfg                      (cfg),
    .clock_start_event        (clock_start_event),
    .flush_reset              (flush_reset),
    .self_test                (self_test),
    .sequencer_sync_clock_in  (sequencer_sync_clock_in),
    .sequencer_sync_clock_out (sequencer_sync_clock_out),
    .sequencer_sync_clock_oe  (sequencer_sync_clock_oe),
    .sequencer_sync_clock_aux (sequencer_sync_clock_aux),
    .slot_start               (slot_start),
    .byte_clock_ratio         (byte_clock_ratio),
    .tree_clock_from_tree     (tree_clock_from_tree),
    .tree_clock_ready         (tree_clock_ready),
    .rx_lanes                 (rx_lanes),
    .rx_valid                 (rx_valid),
    .rx_ready                 (rx_ready),
    .tx_lanes                 (tx_lanes),
    .tx_valid                 (tx_valid),
    .tx_ready                 (tx_ready)
  );
  sync_master_model peer (.clk(clk), .run(run), .sync_o(sequencer_sync_clock_in));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  // A hang counts as a mismatch and ends the run
  task automatic guard(input int lim);
    n++;
    if (n > lim) begin
      bad_count++;
      close_out();
    end
  endtask : guard
  task automatic do_reset(input clk_cfg_t c);
    rstn = 1'b0;
    cfg = c;
    step(4);
    rstn = 1'b1;
  endtask : do_reset
  task automatic slot_len;
    n = 0;
    hi = 0;
    hx = 0;
    do begin
      step(1);
      hi += int'(sequencer_sync_clock_out);
      hx += int'(sequencer_sync_clock_aux);
      guard(200);
    end while (slot_start !== 1'b1);
  endtask : slot_len
  task automatic t_clock;
    do_reset('{1'b1, 1'b1, SEQ_MODE_DRIVE, 3'h0});
    chk(byte_clock_ratio, 0);
    chk(tx_valid, 0);
    step(1);
    chk(rx_ready, 1);
    for (int i = 0; i < 4; i++) begin
      {cfg.pll_internal, cfg.pll_ratio_four} = 2'(i);
      step(2);
      chk(byte_clock_ratio, (i == 3) ? 4 : 2);
    end
  endtask : t_clock
  task automatic t_sync(input logic [2:0] sel, input seq_mode_t m);
    int p;
    p = (sel > 3'h4) ? 20 : 16 + int'(sel);
    do_reset('{1'b0, 1'b0, m, sel});
    slot_len();
    slot_len();
    chk(n, 4 * p);
    chk(sequencer_sync_clock_oe, m == SEQ_MODE_DRIVE);
    chk(hx, 4 * (p / 2));
    chk(hi, (m == SEQ_MODE_DRIVE) ? 4 * (p / 2) : 0);
    if (m == SEQ_MODE_DRIVE) begin
      chk(sequencer_sync_clock_aux, sequencer_sync_clock_out);
    end
  endtask : t_sync
  task automatic t_recv;
    run = 1'b1;
    t_sync(3'h0, SEQ_MODE_RECEIVE);
    v = sequencer_sync_clock_in;
    step(1);
    chk(sequencer_sync_clock_aux, v);
    run = 1'b0;
  endtask : t_recv
  task automatic t_tree(input logic pll);
    do_reset('{pll, 1'b0, SEQ_MODE_TRISTATE, 3'h0});
    clock_start_event = 1'b1;
    step(1);
    clock_start_event = 1'b0;
    n = 0;
    while (tree_clock_ready !== 1'b1) begin
      step(1);
      guard(3000);
    end
    chk(n, pll ? LOCK_CYCLES : 0);
    for (int i = 0; i < 3; i++) begin
      {flush_reset, self_test} = 2'(i);
      step(2);
      chk(tree_clock_from_tree, i == 0);
    end
    {flush_reset, self_test} = 2'h0;
  endtask : t_tree
  task automatic put(input lane_word_t w);
    rx_lanes = w;
    rx_valid = 1'b1;
    n = 0;
    while (rx_ready !== 1'b1) begin
      step(1);
      guard(50);
    end
    step(1);
  endtask : put
  // Receiver stalls while two words go in, then drains them in order
  task automatic t_lanes;
    tx_ready = 1'b0;
    put(64'h0123_4567_89ab_cdef);
    put(64'hfedc_ba98_7654_3210);
    rx_valid = 1'b0;
    chk(rx_ready, 0);
    chk(tx_lanes, 64'h0123_4567_89ab_cdef);
    tx_ready = 1'b1;
    step(1);
    chk(tx_lanes, 64'hfedc_ba98_7654_3210);
    step(1);
    chk(tx_valid, 0);
  endtask : t_lanes
  initial begin
    rstn = 1'b0;
    cfg = '0;
    {clock_start_event, flush_reset, self_test, run} = 4'h0;
    {rx_valid, tx_ready} = 2'h0;
    rx_lanes = '0;
    t_clock();
    t_sync(3'h0, SEQ_MODE_TRISTATE);
    t_sync(3'h0, SEQ_MODE_DRIVE);
    t_sync(3'h4, SEQ_MODE_DRIVE);
    t_sync(3'h7, SEQ_MODE_DRIVE);
    t_recv();
    t_tree(1'b1);
    t_tree(1'b0);
    t_lanes();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
